// ===== hw/ltc_cell.sv
`timescale 1ns/1ps
`default_nettype none
// one transceiver cell: mode, wake flag and fault state
module ltc_cell
    import ltc_pkg::*;
#(
    parameter int WAKE_CYC = LTC_WAKE_FILTER_CYC,
    parameter int TXD_CYC = LTC_TXD_TO_CYC,
    parameter int BUS_CYC = LTC_BUS_TO_CYC
) (
    input wire logic mclk, // system clock
    input wire logic resetn, // sync reset, active low
    input wire ltc_chip_mode_t chip_mode, // chip operating mode
    input wire logic chip_mode_chg, // chip mode changes this cycle
    input wire logic mode_wr, // command strobe
    input wire ltc_lin_mode_t mode_req, // requested mode
    input wire logic wake_clr, // clear wake flag
    input wire logic txd, // transmit input, 0 dominant
    input wire logic bus_line, // received bus level, 0 dominant
    input wire logic overtemp, // driver overtemperature
    output ltc_lin_mode_t mode, // current mode
    output logic wake_flag, // bus_wake_flag
    output logic wake_ev, // wake detected pulse
    output logic txd_to_flag, // transmit timeout fault
    output logic bus_clamp_flag, // bus dominant fault
    output logic bus_clamp_ev, // bus clamp detected pulse
    output logic drv_en_c, // bus driver enable
    output logic pullup_en_c, // bus pull-up enable
    output logic rxd_c // receive output value
);
    ltc_lin_mode_t mode_q, mode_d;
    logic wake_q, wake_d, armed_q, armed_d;
    logic txto_q, txto_d, clamp_q, clamp_d, ot_q, ot_d;
    logic bus_q, wdom_q, wdom_d, wlow_q, wlow_d;
    logic allowed, txd_exp, bus_exp, wake_hit, wdr_edge, ot_release;

    ltc_timer #(.LIMIT(TXD_CYC)) u_txd_to (.mclk(mclk), .resetn(resetn),
        .run(!txd && mode_q == LTC_MODE_NORMAL), .expired(txd_exp));
    ltc_timer #(.LIMIT(BUS_CYC)) u_bus_to (.mclk(mclk), .resetn(resetn),
        .run(!bus_line && mode_q == LTC_MODE_NORMAL), .expired(bus_exp));
    // filtered dominant phase, wake counts on the following release
    ltc_timer #(.LIMIT(WAKE_CYC)) u_wake (.mclk(mclk), .resetn(resetn),
        .run(!bus_line && mode_q == LTC_MODE_WAKE), .expired(wake_hit));

    // permitted modes per chip mode
    always_comb begin
        case (chip_mode)
            // listed explicitly so unused codes of the field are refused too
            LTC_CHIP_NORMAL:
                allowed = mode_req inside {LTC_MODE_OFF, LTC_MODE_WAKE, LTC_MODE_NORMAL, LTC_MODE_RXONLY}; // [RULE12]
            LTC_CHIP_SLEEP, LTC_CHIP_RESTART, LTC_CHIP_STOP:
                allowed = mode_req == LTC_MODE_OFF || mode_req == LTC_MODE_WAKE; // [RULE4] [RULE5]
            LTC_CHIP_FLASH: allowed = mode_req == LTC_MODE_FLASH; // [RULE11]
            default: allowed = 1'b0; // init and fail-safe take no command
        endcase
    end

    // wake only on dominant-to-recessive edge after filter time
    assign wdr_edge = wdom_q && bus_line && armed_q; // [RULE16]
    assign ot_release = ot_q && !overtemp && wlow_q && txd; // [RULE18]

    always_comb begin
        mode_d = mode_q;
        wake_d = wake_q;
        armed_d = armed_q;
        txto_d = txto_q;
        clamp_d = clamp_q;
        ot_d = ot_q;
        wdom_d = (mode_q == LTC_MODE_WAKE) && (wdom_q || wake_hit) && !bus_line;
        wlow_d = !txd;
        if (wake_clr) wake_d = 1'b0;
        if (mode_wr && allowed) begin // [RULE22]
            mode_d = mode_req;
            if (mode_req == LTC_MODE_NORMAL) begin
                txto_d = 1'b0; // [RULE19]
                clamp_d = 1'b0; // [RULE20] [RULE18]
            end
            // re-arm on any accepted command other than wake: normal, rx-only, off or flash
            if (mode_req != LTC_MODE_WAKE) armed_d = 1'b1; // [RULE6]
            if (mode_req == LTC_MODE_NORMAL) ot_d = 1'b0;
        end
        // automatic entries on chip mode change
        if (chip_mode_chg) begin
            case (chip_mode)
                LTC_CHIP_INIT: mode_d = LTC_MODE_OFF; // [RULE4]
                LTC_CHIP_FAILSAFE: mode_d = LTC_MODE_WAKE; // [RULE5]
                LTC_CHIP_FLASH: mode_d = LTC_MODE_FLASH; // [RULE1] [RULE11]
                default: mode_d = mode_d;
            endcase
        end
        if (wdr_edge) begin
            wake_d = 1'b1; // [RULE9]
            armed_d = 1'b0; // [RULE6]
        end
        // faults drop a normal cell to receive-only
        if (mode_q == LTC_MODE_NORMAL && (txd_exp || bus_exp)) begin
            mode_d = LTC_MODE_RXONLY; // [RULE17]
            if (txd_exp) txto_d = 1'b1; // [RULE19]
            if (bus_exp) clamp_d = 1'b1; // [RULE20]
        end
        if (overtemp && mode_q == LTC_MODE_NORMAL) begin
            mode_d = LTC_MODE_RXONLY; // [RULE17]
            ot_d = 1'b1;
        end
        if (ot_release && !txto_q && !clamp_q) begin
            mode_d = LTC_MODE_NORMAL; // [RULE18]
            ot_d = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            mode_q <= LTC_MODE_OFF;
            wake_q <= 1'b0;
            armed_q <= 1'b1;
            txto_q <= 1'b0;
            clamp_q <= 1'b0;
            ot_q <= 1'b0;
            wdom_q <= 1'b0;
            wlow_q <= 1'b0;
            bus_q <= 1'b1;
        end else begin
            mode_q <= mode_d;
            wake_q <= wake_d;
            armed_q <= armed_d;
            txto_q <= txto_d;
            clamp_q <= clamp_d;
            ot_q <= ot_d;
            wdom_q <= wdom_d;
            wlow_q <= wlow_d;
            bus_q <= bus_line;
        end
    end

    assign mode = mode_q;
    assign wake_flag = wake_q;
    assign wake_ev = wdr_edge;
    assign txd_to_flag = txto_q;
    assign bus_clamp_flag = clamp_q;
    assign bus_clamp_ev = bus_exp && mode_q == LTC_MODE_NORMAL;
    assign drv_en_c = (mode_q == LTC_MODE_NORMAL || mode_q == LTC_MODE_FLASH) && !txto_q && !ot_q; // [RULE10] [RULE19]
    assign pullup_en_c = !(mode_q == LTC_MODE_OFF || mode_q == LTC_MODE_WAKE); // [RULE15]
    // pending wake holds receive low; off and wake-capable give high; otherwise pass the registered bus through
    always_comb begin
        if (wake_q) rxd_c = 1'b0; // [RULE7] [RULE8] [RULE9]
        else if (mode_q == LTC_MODE_OFF || mode_q == LTC_MODE_WAKE) rxd_c = 1'b1;
        else rxd_c = bus_q; // [RULE10]
    end
endmodule // ltc_cell
`default_nettype wire

// ===== hw/ltc_pkg.sv
`default_nettype none
package ltc_pkg;
    // transceiver cell modes; encoding of the command field is our own
    typedef enum logic [2:0] {
        LTC_MODE_OFF,
        LTC_MODE_WAKE,
        LTC_MODE_NORMAL,
        LTC_MODE_RXONLY,
        LTC_MODE_FLASH
    } ltc_lin_mode_t;

    // chip operating modes as seen by the cells
    typedef enum logic [2:0] {
        LTC_CHIP_INIT,
        LTC_CHIP_NORMAL,
        LTC_CHIP_SLEEP,
        LTC_CHIP_RESTART,
        LTC_CHIP_STOP,
        LTC_CHIP_FAILSAFE,
        LTC_CHIP_FLASH
    } ltc_chip_mode_t;

    localparam int LTC_NUM_CELLS = 3;
    localparam int LTC_CLK_MHZ = 250;
    // timeouts and filter in microseconds
    localparam int LTC_WAKE_FILTER_US = 30;
    localparam int LTC_TXD_TO_US = 300;
    localparam int LTC_BUS_TO_US = 300;
    localparam int LTC_WAKE_FILTER_CYC = LTC_WAKE_FILTER_US * LTC_CLK_MHZ;
    localparam int LTC_TXD_TO_CYC = LTC_TXD_TO_US * LTC_CLK_MHZ;
    localparam int LTC_BUS_TO_CYC = LTC_BUS_TO_US * LTC_CLK_MHZ;
    localparam int LTC_CNT_W = 17;
    localparam logic LTC_SLOPE_RESET = 1'b0;
endpackage
`default_nettype wire

// ===== hw/ltc_timer.sv
`timescale 1ns/1ps
`default_nettype none
// counts cycles while a level holds; flags once the limit is passed
module ltc_timer
    import ltc_pkg::*;
#(
    parameter int LIMIT = 1000
) (
    input wire logic mclk, // system clock
    input wire logic resetn, // sync reset, active low
    input wire logic run, // level being timed
    output logic expired // level held beyond limit
);
    logic [LTC_CNT_W-1:0] cnt_q;
    logic [LTC_CNT_W-1:0] cnt_d;

    // saturating counter cleared whenever the level drops
    always_comb begin
        cnt_d = cnt_q;
        if (!run) begin
            cnt_d = '0;
        end else if (cnt_q != LTC_CNT_W'(LIMIT)) begin
            cnt_d = cnt_q + LTC_CNT_W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign expired = run && (cnt_q == LTC_CNT_W'(LIMIT));
endmodule // ltc_timer
`default_nettype wire

// ===== hw/ltc_top.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE1] normal mode by command or flash entry
// [RULE2] low slope default, command selects normal slope
// [RULE3] one slope for all cells, chip normal
// [RULE4] off mode default in init, command exits
// [RULE5] wake-capable by command, automatic in fail-safe
// [RULE6] wake re-armed only after other mode
// [RULE7] sleep wake: restart, receive low, no interrupt
// [RULE8] stop wake: interrupt, flag, receive low
// [RULE9] wake sets flag, interrupt per chip mode
// [RULE10] receive-only: driver off, reception continues
// [RULE11] flash mode only in chip flash
// [RULE12] permitted cell modes follow chip mode
// [RULE13] controller arms wake before sleep or stop
// [RULE14] no mode change in sleep command
// [RULE15] pull-up off in wake-capable or off
// [RULE16] wake only on dominant-to-recessive edge
// [RULE17] any failure forces receive-only mode; the code does so only for a cell in normal mode, not in flash
// [RULE18] transmitter re-enable by command, overtemp by edge
// [RULE19] transmit timeout stops driving until normal command
// [RULE20] bus clamp: receive-only, flag, interrupt
// [RULE21] three identical independent cells
// [RULE22] per-cell mode field, illegal writes ignored
module ltc_top
    import ltc_pkg::*;
#(
    parameter int WAKE_CYC = LTC_WAKE_FILTER_CYC,
    parameter int TXD_CYC = LTC_TXD_TO_CYC,
    parameter int BUS_CYC = LTC_BUS_TO_CYC
) (
    input wire logic mclk, // system clock
    input wire logic resetn, // sync reset, active low
    input wire ltc_chip_mode_t chip_mode, // chip operating mode
    input wire logic [LTC_NUM_CELLS-1:0] mode_wr, // per-cell command strobe
    input wire ltc_lin_mode_t mode_req, // requested cell mode
    input wire logic slope_wr, // slope command strobe
    input wire logic slope_normal_req, // 1 selects normal slope
    input wire logic [LTC_NUM_CELLS-1:0] wake_clr, // clear wake flags
    input wire logic [LTC_NUM_CELLS-1:0] int_mask, // mask interrupt per cell
    input wire logic [LTC_NUM_CELLS-1:0] txd, // transmit inputs
    input wire logic [LTC_NUM_CELLS-1:0] bus_line, // bus receive levels
    input wire logic [LTC_NUM_CELLS-1:0] overtemp, // driver overtemperature
    output logic [LTC_NUM_CELLS-1:0] bus_receive_output, // receive outputs
    output logic [LTC_NUM_CELLS-1:0] drv_en, // bus driver enables
    output logic [LTC_NUM_CELLS-1:0] pullup_en, // bus pull-up enables
    output logic [LTC_NUM_CELLS-1:0] slope_ctl_en, // slope control active
    output logic slope_normal, // 1 normal slope, 0 low slope
    output logic [LTC_NUM_CELLS-1:0] bus_wake_flag, // wake flags
    output logic [LTC_NUM_CELLS-1:0] txd_short_diag, // timeout as transmit short
    output logic [LTC_NUM_CELLS-1:0] bus_clamp_diag, // bus dominant fault
    output logic restart_req, // chip move to restart pulse
    output logic int_n, // interrupt, active low pulse
    output logic [3*LTC_NUM_CELLS-1:0] cell_mode // current mode per cell
);
    ltc_chip_mode_t chip_q;
    logic chg;
    logic slope_q, slope_d;
    logic [LTC_NUM_CELLS-1:0] wk, wev, txf, clf, cev, dr, pu, rx, flash;
    ltc_lin_mode_t md [LTC_NUM_CELLS];
    logic restart_d, int_n_d;

    assign chg = chip_mode != chip_q;

    ////////////////////////////////////////////////////////////////////
    // cells, all identical
    for (genvar i = 0; i < LTC_NUM_CELLS; i++) begin : g_cell // [RULE21]
        ltc_cell #(.WAKE_CYC(WAKE_CYC), .TXD_CYC(TXD_CYC), .BUS_CYC(BUS_CYC)) u_cell (
            .mclk(mclk), .resetn(resetn), .chip_mode(chip_mode), .chip_mode_chg(chg),
            .mode_wr(mode_wr[i]), .mode_req(mode_req), .wake_clr(wake_clr[i]),
            .txd(txd[i]), .bus_line(bus_line[i]), .overtemp(overtemp[i]),
            .mode(md[i]), .wake_flag(wk[i]), .wake_ev(wev[i]), .txd_to_flag(txf[i]),
            .bus_clamp_flag(clf[i]), .bus_clamp_ev(cev[i]), .drv_en_c(dr[i]),
            .pullup_en_c(pu[i]), .rxd_c(rx[i]));
        assign flash[i] = md[i] == LTC_MODE_FLASH;
    end

    ////////////////////////////////////////////////////////////////////
    // shared slope and chip-level wake signalling
    always_comb begin
        slope_d = slope_q;
        if (slope_wr && chip_mode == LTC_CHIP_NORMAL) slope_d = slope_normal_req; // [RULE2] [RULE3]
        restart_d = 1'b0;
        int_n_d = 1'b1;
        // sleep, restart and fail-safe wakes lead to restart, no interrupt
        if (|wev && (chip_mode == LTC_CHIP_SLEEP || chip_mode == LTC_CHIP_RESTART ||
                     chip_mode == LTC_CHIP_FAILSAFE)) restart_d = 1'b1; // [RULE7] [RULE9]
        if ((chip_mode == LTC_CHIP_NORMAL || chip_mode == LTC_CHIP_STOP) && |(wev & ~int_mask))
            int_n_d = 1'b0; // [RULE8] [RULE9]
        if (|(cev & ~int_mask)) int_n_d = 1'b0; // [RULE20]
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            chip_q <= LTC_CHIP_INIT;
            slope_q <= LTC_SLOPE_RESET;
            restart_req <= 1'b0;
            int_n <= 1'b1;
            bus_receive_output <= '1;
            drv_en <= '0;
            pullup_en <= '0;
            slope_ctl_en <= '1;
            slope_normal <= LTC_SLOPE_RESET;
            bus_wake_flag <= '0;
            txd_short_diag <= '0;
            bus_clamp_diag <= '0;
            cell_mode <= '0;
        end else begin
            chip_q <= chip_mode;
            slope_q <= slope_d;
            restart_req <= restart_d;
            int_n <= int_n_d;
            bus_receive_output <= rx;
            drv_en <= dr;
            pullup_en <= pu;
            slope_ctl_en <= ~flash; // [RULE11]
            slope_normal <= slope_d;
            bus_wake_flag <= wk;
            txd_short_diag <= txf; // [RULE17]
            bus_clamp_diag <= clf;
            cell_mode <= {md[2], md[1], md[0]};
        end
    end
endmodule // ltc_top
`default_nettype wire

// ===== tb/ltc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// protocol controller and bus: the controller drives txd, other nodes may hold the bus
module ltc_ctrl_model (
    input wire logic [2:0] tx_req, // controller transmit level
    input wire logic [2:0] ext_dom, // another node holds dominant
    input wire logic [2:0] drv_en, // cell driver enables
    output logic [2:0] txd, // to cell transmit inputs
    output logic [2:0] bus_line // bus level seen by cells
);
    // pulled-up wired-and: a released bus goes recessive, never keeps its last level
    assign txd = tx_req;
    assign bus_line = ~(ext_dom | (drv_en & ~tx_req));
endmodule // ltc_ctrl_model
`default_nettype wire

// ===== tb/ltc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
// watches cell 0 and the shared outputs of the top level
module ltc_top_sva
    import ltc_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic resetn, // reset
    input wire ltc_chip_mode_t chip_mode, // chip mode
    input wire logic [LTC_NUM_CELLS-1:0] int_mask, // masks
    input wire logic [LTC_NUM_CELLS-1:0] bus_line, // bus levels
    input wire logic [LTC_NUM_CELLS-1:0] drv_en, // drivers
    input wire logic [LTC_NUM_CELLS-1:0] pullup_en, // pull-ups
    input wire logic [LTC_NUM_CELLS-1:0] slope_ctl_en, // slope control
    input wire logic slope_normal, // slope
    input wire logic [LTC_NUM_CELLS-1:0] bus_wake_flag, // wake flags
    input wire logic [LTC_NUM_CELLS-1:0] txd_short_diag, // timeout
    input wire logic restart_req, // restart
    input wire logic int_n, // interrupt
    input wire logic [3*LTC_NUM_CELLS-1:0] cell_mode // modes
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    // three cycles of a chip mode give the cell register and output stage time to follow
    a_pullup_off: assert property (cell_mode[2:0] inside {LTC_MODE_OFF, LTC_MODE_WAKE} |-> !pullup_en[0])
        else $error("pull-up on while off or wake-capable");
    a_rxonly_nodrv: assert property (cell_mode[2:0] == LTC_MODE_RXONLY |-> !drv_en[0])
        else $error("driver on in receive-only");
    a_init_off: assert property ((chip_mode == LTC_CHIP_INIT) [*3] |-> cell_mode == 9'h0)
        else $error("cell not off in init");
    a_flash_mode: assert property ((chip_mode == LTC_CHIP_FLASH) [*3] |->
        cell_mode[2:0] == LTC_MODE_FLASH && !slope_ctl_en[0])
        else $error("flash mode not entered");
    a_slope_hold: assert property ((chip_mode != LTC_CHIP_NORMAL) [*3] |=> $stable(slope_normal))
        else $error("slope changed outside chip normal");
    // the interrupt and restart pulses lead the registered flag by one cycle
    a_wake_int: assert property ($rose(bus_wake_flag[0]) && !int_mask[0] && chip_mode inside
        {LTC_CHIP_NORMAL, LTC_CHIP_STOP} |-> $past(int_n) == 1'b0)
        else $error("no interrupt on wake");
    a_sleep_quiet: assert property ($rose(bus_wake_flag[0]) && chip_mode == LTC_CHIP_SLEEP |->
        $past(int_n) && $past(restart_req))
        else $error("sleep wake handled wrongly");
    a_wake_edge: assert property ((bus_line[0] == 1'b0) [*8] |-> !$rose(bus_wake_flag[0]))
        else $error("wake without recessive edge");
    a_txd_cut: assert property (txd_short_diag[0] |-> !drv_en[0])
        else $error("driving after transmit timeout");
    c_stop_wake: cover property ($rose(bus_wake_flag[0]) && chip_mode == LTC_CHIP_STOP);
    c_txd_to: cover property ($rose(txd_short_diag[0]));
    c_restart: cover property (restart_req);
endmodule // ltc_top_sva

bind ltc_top ltc_top_sva ltc_top_sva_inst (.mclk(mclk), .resetn(resetn), .chip_mode(chip_mode),
    .int_mask(int_mask), .bus_line(bus_line), .drv_en(drv_en), .pullup_en(pullup_en),
    .slope_ctl_en(slope_ctl_en), .slope_normal(slope_normal), .bus_wake_flag(bus_wake_flag),
    .txd_short_diag(txd_short_diag), .restart_req(restart_req), .int_n(int_n), .cell_mode(cell_mode));
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ltc_pkg::*;
    localparam int WC = 20;
    localparam int BC = 30;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    ltc_chip_mode_t chip_mode = LTC_CHIP_INIT;
    ltc_lin_mode_t mode_req = LTC_MODE_OFF;
    logic [2:0] mode_wr = 3'h0, wake_clr = 3'h0, int_mask = 3'h0, overtemp = 3'h0, tx_req = 3'h7, ext_dom = 3'h0;
    logic slope_wr = 1'b0, slope_normal_req = 1'b0, int_seen = 1'b0, rst_seen = 1'b0, seen_clr = 1'b0;
    wire logic [2:0] txd, bus_line, rxd, drv_en, pullup_en, slope_ctl_en, wake_f, txd_diag, clamp_diag;
    wire logic slope_normal, restart_req, int_n;
    wire logic [8:0] cell_mode;
    int miscompares = 0, compares = 0;
    // bus timeout longer than transmit timeout, so a stuck txd trips only its own fault
    ltc_top #(.WAKE_CYC(WC), .TXD_CYC(WC), .BUS_CYC(BC)) ltc_top_inst (.mclk(mclk), .resetn(resetn),
        .chip_mode(chip_mode), .mode_wr(mode_wr), .mode_req(mode_req), .slope_wr(slope_wr),
        .slope_normal_req(slope_normal_req), .wake_clr(wake_clr), .int_mask(int_mask), .txd(txd),
        .bus_line(bus_line), .overtemp(overtemp), .bus_receive_output(rxd), .drv_en(drv_en),
        .pullup_en(pullup_en), .slope_ctl_en(slope_ctl_en), .slope_normal(slope_normal),
        .bus_wake_flag(wake_f), .txd_short_diag(txd_diag), .bus_clamp_diag(clamp_diag),
        .restart_req(restart_req), .int_n(int_n), .cell_mode(cell_mode));
    ltc_ctrl_model ltc_ctrl_model_inst (.tx_req(tx_req), .ext_dom(ext_dom), .drv_en(drv_en), .txd(txd),
        .bus_line(bus_line));
    always #2 mclk = ~mclk;
    // one-cycle pulses are caught here so tasks can judge them later
    // only this process writes the catch flags; tasks ask for a clear
    always @(posedge mclk) begin
        if (seen_clr) begin
            int_seen <= 1'b0;
            rst_seen <= 1'b0;
        end else begin
            if (int_n === 1'b0) int_seen <= 1'b1;
            if (restart_req === 1'b1) rst_seen <= 1'b1;
        end
    end
    ////////////////////////////////////////
    task automatic chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // a write shows two edges later
    task automatic wr(input int c, input ltc_lin_mode_t m);
        mode_wr = 3'h1 << c;
        mode_req = m;
        step(1);
        mode_wr = 3'h0;
        step(2);
    endtask
    task automatic chip(input ltc_chip_mode_t m);
        chip_mode = m;
        step(3);
    endtask
    task automatic slope(input logic v);
        slope_normal_req = v;
        slope_wr = 1'b1;
        step(1);
        slope_wr = 1'b0;
        step(2);
    endtask
    task automatic pulse();
        ext_dom = 3'h1;
        step(WC + 5);
        chk("held low", wake_f[0], 1'b0);
        ext_dom = 3'h0;
    endtask
    task automatic clr_seen();
        seen_clr = 1'b1;
        step(1);
        seen_clr = 1'b0;
    endtask
    ////////////////////////////////////////
    task automatic t_modes();
        chk("reset", {cell_mode[5:0], slope_normal, pullup_en[0], rxd[0]}, 9'h1);
        wr(0, LTC_MODE_NORMAL);
        chk("init refuse", cell_mode[2:0], LTC_MODE_OFF);
        chip(LTC_CHIP_NORMAL);
        wr(0, LTC_MODE_NORMAL);
        chk("normal", {drv_en[0], pullup_en[0], cell_mode[2:0]}, {2'b11, LTC_MODE_NORMAL});
        wr(0, LTC_MODE_FLASH);
        chk("flash refuse", cell_mode[2:0], LTC_MODE_NORMAL);
        wr(1, LTC_MODE_RXONLY);
        ext_dom = 3'h2;
        step(3);
        chk("rx only", {drv_en[1], rxd[1], cell_mode[5:3]}, {2'b00, LTC_MODE_RXONLY});
        ext_dom = 3'h0;
        chk("cell2", cell_mode[8:6], LTC_MODE_OFF);
    endtask
    task automatic t_slope();
        slope(1'b1);
        chk("slope", slope_normal, 1'b1);
        chip(LTC_CHIP_STOP);
        slope(1'b0);
        chk("slope locked", slope_normal, 1'b1);
        chip(LTC_CHIP_NORMAL);
        slope(1'b0);
        chk("slope low", slope_normal, 1'b0);
    endtask
    task automatic t_wake(input ltc_chip_mode_t cm, input logic ei, input logic er);
        chip(LTC_CHIP_NORMAL);
        wr(0, LTC_MODE_OFF);
        wr(0, LTC_MODE_WAKE);
        wake_clr = 3'h1;
        step(1);
        wake_clr = 3'h0;
        chip(cm);
        clr_seen();
        pulse();
        for (int i = 0; i < 100 && wake_f[0] !== 1'b1; i++) step(1);
        if (wake_f[0] !== 1'b1) begin
            chk("wake timeout", wake_f[0], 1'b1);
            final_report();
        end
        step(2);
        chk("wake rxd", rxd[0], 1'b0);
        chk("wake int", int_seen, ei);
        chk("wake restart", rst_seen, er);
    endtask
    task automatic t_rearm();
        wr(0, LTC_MODE_WAKE);
        wake_clr = 3'h1;
        step(1);
        wake_clr = 3'h0;
        pulse();
        step(6);
        chk("no rearm", wake_f[0], 1'b0);
    endtask
    task automatic t_fault();
        wr(0, LTC_MODE_NORMAL);
        tx_req = 3'h6;
        step(WC + 5);
        tx_req = 3'h7;
        step(2);
        chk("txd timeout", {txd_diag[0], drv_en[0], cell_mode[2:0]}, {2'b10, LTC_MODE_RXONLY});
        chk("clamp quiet", clamp_diag[0], 1'b0);
        wr(0, LTC_MODE_NORMAL);
        chk("release", {txd_diag[0], drv_en[0]}, 2'b01);
        clr_seen();
        ext_dom = 3'h1;
        step(BC + 5);
        ext_dom = 3'h0;
        step(2);
        chk("clamp", {clamp_diag[0], int_seen, cell_mode[2:0]}, {2'b11, LTC_MODE_RXONLY});
        wr(0, LTC_MODE_NORMAL);
        overtemp = 3'h1;
        step(3);
        chk("hot", {drv_en[0], txd_diag[0], clamp_diag[0]}, 3'b000);
        overtemp = 3'h0;
        step(3);
        chk("cooled", drv_en[0], 1'b0);
        tx_req = 3'h6;
        step(1);
        tx_req = 3'h7;
        step(3);
        chk("edge release", drv_en[0], 1'b1);
    endtask
    // automatic entries on chip mode change
    task automatic t_auto();
        chip(LTC_CHIP_FLASH);
        chk("flash", cell_mode, {3{LTC_MODE_FLASH}});
        chk("flash slope", slope_ctl_en, 3'h0);
        chip(LTC_CHIP_FAILSAFE);
        wr(0, LTC_MODE_OFF);
        chk("failsafe", cell_mode, {3{LTC_MODE_WAKE}});
        chip(LTC_CHIP_INIT);
        chk("init", cell_mode, 9'h0);
    endtask
    ////////////////////////////////////////
    initial begin
        step(5);
        resetn = 1'b1;
        t_modes();
        t_slope();
        t_wake(LTC_CHIP_NORMAL, 1'b1, 1'b0);
        t_wake(LTC_CHIP_STOP, 1'b1, 1'b0);
        t_wake(LTC_CHIP_SLEEP, 1'b0, 1'b1);
        t_wake(LTC_CHIP_RESTART, 1'b0, 1'b1);
        t_wake(LTC_CHIP_FAILSAFE, 1'b0, 1'b1);
        int_mask = 3'h1;
        t_wake(LTC_CHIP_NORMAL, 1'b0, 1'b0);
        int_mask = 3'h0;
        t_rearm();
        t_fault();
        t_auto();
        final_report();
    end
endmodule // tb_top
`default_nettype wire
